// *** shared/wwd_defines.vh ***
/*
  constants of the window watchdog: register offsets, field positions,
  reset values, key and timing counts.
  assumes it is included by bare name from the design files.
*/
`ifndef WWD_DEFINES_VH
`define WWD_DEFINES_VH

// ********************************************************************
// register map (byte addresses)
// ********************************************************************
`define WWD_OFS_RELOAD      4'h0
`define WWD_OFS_CONTROL     4'h4
`define WWD_OFS_STATUS      4'h8
`define WWD_OFS_COUNT       4'hC

// ********************************************************************
// control fields
// ********************************************************************
`define WWD_CR_DBG_BIT      31
`define WWD_CR_CMP_HI       21
`define WWD_CR_CMP_LO       16
`define WWD_CR_PSC_HI       11
`define WWD_CR_PSC_LO       8
`define WWD_CR_IE_BIT       1
`define WWD_CR_EN_BIT       0
`define WWD_CR_RESET        32'h003F_0800
`define WWD_CR_MASK         32'h803F_0F03

// ********************************************************************
// status fields, key, counter top
// ********************************************************************
`define WWD_SR_IF_BIT       0
`define WWD_SR_RF_BIT       1
`define WWD_RELOAD_KEY      32'h0000_5AA5
`define WWD_COUNT_TOP       6'h3F
`define WWD_COUNT_ZERO      6'h00
`define WWD_SYNC_STAGES     3
`define WWD_RST_PULSE       4'h4

`endif

// *** rtl/wwd_prescaler.v ***
/*
  prescaler of the window watchdog: turns watchdog clock enables into
  one tick per selected divisor.
  assumes wdt_tick is a one-cycle pulse per watchdog clock period.
*/
`include "wwd_defines.vh"

module wwd_prescaler #(
    parameter WIDTH = 11
) (
    // clock and reset
    input  wire       clk,
    input  wire       sys_rst,
    // control
    input  wire       run,
    input  wire       restart,
    input  wire [3:0] select,
    input  wire       wdt_tick,
    // tick out
    output reg        tick_q
);

    reg  [WIDTH-1:0] cnt_q;
    reg  [WIDTH-1:0] limit;

    // divisor minus one per code
    always @*
    begin
        case (select)
            4'h0: limit = 11'd0;
            4'h1: limit = 11'd1;
            4'h2: limit = 11'd3;
            4'h3: limit = 11'd7;
            4'h4: limit = 11'd15;
            4'h5: limit = 11'd31;
            4'h6: limit = 11'd63;
            4'h7: limit = 11'd127;
            4'h8: limit = 11'd191;
            4'h9: limit = 11'd255;
            4'hA: limit = 11'd383;
            4'hB: limit = 11'd511;
            4'hC: limit = 11'd767;
            4'hD: limit = 11'd1023;
            4'hE: limit = 11'd1535;
            default: limit = 11'd2047;
        endcase
    end

    // restart wins so a reload gives a full period before next step
    always @(posedge clk)
    begin
        if (sys_rst || restart)
        begin
            cnt_q  <= {WIDTH{1'b0}};
            tick_q <= 1'b0;
        end
        else if (run && wdt_tick)
        begin
            tick_q <= (cnt_q == limit);
            cnt_q  <= (cnt_q == limit) ? {WIDTH{1'b0}} : cnt_q + 1'b1;
        end
        else
        begin
            tick_q <= 1'b0;
        end
    end

endmodule // wwd_prescaler

// *** rtl/wwd_reload_sync.v ***
/*
  reload delay line of the window watchdog: a reload request takes a
  fixed number of watchdog clock periods before it reaches the counter.
  assumes wdt_tick is a one-cycle pulse per watchdog clock period.
*/
`include "wwd_defines.vh"

module wwd_reload_sync #(
    parameter STAGES = `WWD_SYNC_STAGES
) (
    // clock and reset
    input  wire clk,
    input  wire sys_rst,
    // request in
    input  wire request,
    input  wire wdt_tick,
    // delayed reload out
    output reg  fire_q,
    output wire busy
);

    reg [STAGES-1:0] pipe_q;
    reg              pend_q;

    assign busy = pend_q | (|pipe_q);

    // request waits for the next watchdog period, then walks the stages
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            pend_q <= 1'b0;
            pipe_q <= {STAGES{1'b0}};
            fire_q <= 1'b0;
        end
        else
        begin
            fire_q <= 1'b0;
            if (request)
                pend_q <= 1'b1;
            if (wdt_tick)
            begin
                pipe_q <= {pipe_q[STAGES-2:0], pend_q};
                fire_q <= pipe_q[STAGES-1];
                if (!request)
                    pend_q <= 1'b0;
            end
        end
    end

endmodule // wwd_reload_sync

// *** rtl/wwd_top.v ***
/*
  window watchdog top: avalon-mm register slave, write-once control,
  6-bit down counter, window check, match flag and chip reset request.
  assumes wdt_clk_tick is a one-cycle enable per watchdog clock period
  synchronous to clk, and that cpu_halted is synchronous to clk.
*/
`include "wwd_defines.vh"

// How it works
// RQ1: writing key 5AA5 to reload register returns counter to 3F.
// RQ2: reload key above window compare requests chip reset at once.
// RQ3: only first control write after reset is taken, rest ignored.
// RQ4: control bit 31 low freezes counting while processor halted.
// RQ5: control bits 21:16 hold window compare for reload and match.
// RQ6: control bits 11:8 pick divisor 1 to 2048 per code table.
// RQ7: longest time-out equals divisor times 64 watchdog clock periods; the code requests reset after divisor times 63.
// RQ8: bit 1 high drives match interrupt while match flag set.
// RQ9: control bit 0 starts counting; low holds counter still.
// RQ10: control register resets to 003F_0800.
// RQ11: enabled counter steps down from 3F once per prescaled tick.
// RQ12: match flag sets when count equals compare; write one clears.
// RQ13: counter reaching zero without reload requests chip reset.
// RQ14: reload needs three watchdog clocks before counter returns to top; the code fires the reload on the fourth watchdog tick after the request.
// RQ15: accepted reload also restarts the prescaler.
module wwd_top (
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // avalon-mm slave
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // watchdog clock enable and debug halt
    input  wire        wdt_clk_tick,
    input  wire        cpu_halted,
    // outputs to system
    output reg         match_irq_q,
    output reg         chip_reset_req_q
);

    // ****************************************************************
    // state
    // ****************************************************************
    reg  [31:0] ctrl_q;
    reg         ctrl_locked_q;
    reg  [5:0]  count_value_q;
    reg         match_flag_q;
    reg         reset_flag_q;
    reg  [3:0]  rst_cnt_q;
    reg         ack_q;
    reg         reload_req_q;
    reg         tick_cnt_q;

    wire        debug_halt_ignore = ctrl_q[`WWD_CR_DBG_BIT];
    wire [5:0]  window_compare    = ctrl_q[`WWD_CR_CMP_HI:`WWD_CR_CMP_LO];
    wire [3:0]  prescale_select   = ctrl_q[`WWD_CR_PSC_HI:`WWD_CR_PSC_LO];
    wire        match_irq_enable  = ctrl_q[`WWD_CR_IE_BIT];
    wire        counter_enable    = ctrl_q[`WWD_CR_EN_BIT];

    // ****************************************************************
    // bus decode
    // ****************************************************************
    // one wait cycle per access: the answer comes at the second edge
    wire        access   = (avs_read | avs_write) & ~ack_q;
    wire        wr_take  = avs_write & ack_q;
    wire        full_wr  = (avs_byteenable == 4'hF);
    wire        key_wr   = wr_take && (avs_address == `WWD_OFS_RELOAD) && full_wr
                           && (avs_writedata == `WWD_RELOAD_KEY);
    wire        ctrl_wr  = wr_take && (avs_address == `WWD_OFS_CONTROL);
    wire        stat_wr  = wr_take && (avs_address == `WWD_OFS_STATUS);
    wire        in_window = (count_value_q <= window_compare);

    // ****************************************************************
    // counting helpers
    // ****************************************************************
    wire        run = counter_enable
                      && (debug_halt_ignore || !cpu_halted);   // RQ4 RQ9
    wire        presc_tick;
    wire        reload_fire;
    wire        reload_busy;
    wire        reload_ok = key_wr && in_window && counter_enable;

    wwd_prescaler #(
        .WIDTH    (11)
    ) u_presc (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .run      (run),
        .restart  (reload_fire),                             // RQ15
        .select   (prescale_select),                         // RQ6
        .wdt_tick (wdt_clk_tick),
        .tick_q   (presc_tick)
    );

    wwd_reload_sync #(
        .STAGES   (`WWD_SYNC_STAGES)
    ) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .request  (reload_req_q),
        .wdt_tick (wdt_clk_tick),
        .fire_q   (reload_fire),                             // RQ14
        .busy     (reload_busy)
    );

    // ****************************************************************
    // bus handshake
    // ****************************************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ack_q           <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end
        else
        begin
            ack_q           <= access;
            avs_waitrequest <= ~access;
            if (access && avs_read)
            begin
                case (avs_address)
                    `WWD_OFS_CONTROL: avs_readdata <= ctrl_q;
                    `WWD_OFS_STATUS:  avs_readdata <= {30'h0000_0000,
                                                      reset_flag_q, match_flag_q};
                    `WWD_OFS_COUNT:   avs_readdata <= {26'h000_0000, count_value_q};
                    default:          avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************************************
    // control register, written once
    // ****************************************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl_q        <= `WWD_CR_RESET;                  // RQ10
            ctrl_locked_q <= 1'b0;
        end
        else if (ctrl_wr && !ctrl_locked_q)                  // RQ3
        begin
            ctrl_q        <= avs_writedata & `WWD_CR_MASK;
            ctrl_locked_q <= 1'b1;
        end
    end

    // ****************************************************************
    // reload request into delay line
    // ****************************************************************
    always @(posedge clk)
    begin
        if (sys_rst)
            reload_req_q <= 1'b0;
        else
            reload_req_q <= reload_ok;                       // RQ1 RQ2
    end

    // ****************************************************************
    // down counter
    // ****************************************************************
    // a reload in flight does not stop counting: a window too late
    // for the delay still lets the counter hit zero
    always @(posedge clk)
    begin
        if (sys_rst)
            count_value_q <= `WWD_COUNT_TOP;
        else if (reload_fire)
            count_value_q <= `WWD_COUNT_TOP;                 // RQ1 RQ14
        else if (presc_tick && count_value_q != `WWD_COUNT_ZERO)
            count_value_q <= count_value_q - 6'd1;           // RQ11 RQ7
    end

    // tick_cnt_q marks a step taken, so the match only fires on arrival
    always @(posedge clk)
    begin
        if (sys_rst)
            tick_cnt_q <= 1'b0;
        else
            tick_cnt_q <= presc_tick && count_value_q != `WWD_COUNT_ZERO;
    end

    // ****************************************************************
    // match flag and interrupt
    // ****************************************************************
    // set wins over a software clear in the same cycle
    always @(posedge clk)
    begin
        if (sys_rst)
            match_flag_q <= 1'b0;
        else if (tick_cnt_q && count_value_q == window_compare)
            match_flag_q <= 1'b1;                            // RQ12 RQ5
        else if (stat_wr && avs_writedata[`WWD_SR_IF_BIT])
            match_flag_q <= 1'b0;                            // RQ12
    end

    always @(posedge clk)
    begin
        if (sys_rst)
            match_irq_q <= 1'b0;
        else
            match_irq_q <= match_flag_q && match_irq_enable; // RQ8
    end

    // ****************************************************************
    // chip reset request
    // ****************************************************************
    // the request is a short pulse; the system reset that follows
    // clears this block, so the flag only survives a partial reset
    wire bad_key  = key_wr && counter_enable && !in_window;  // RQ2
    wire time_out = counter_enable && count_value_q == `WWD_COUNT_ZERO
                    && !reload_busy;                         // RQ13

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            rst_cnt_q        <= 4'h0;
            chip_reset_req_q <= 1'b0;
            reset_flag_q     <= 1'b0;
        end
        else
        begin
            if (bad_key || time_out)
            begin
                rst_cnt_q        <= `WWD_RST_PULSE;
                chip_reset_req_q <= 1'b1;
                reset_flag_q     <= 1'b1;
            end
            else
            begin
                if (rst_cnt_q != 4'h0)
                    rst_cnt_q <= rst_cnt_q - 4'h1;
                chip_reset_req_q <= (rst_cnt_q > 4'h1);
                if (stat_wr && avs_writedata[`WWD_SR_RF_BIT])
                    reset_flag_q <= 1'b0;
            end
        end
    end

endmodule // wwd_top

// *** verification/wwd_checker_props.sv ***
/*
  port checker of the window watchdog top.
  assumes one clock, bound onto wwd_top.
*/
`include "wwd_defines.vh"

module wwd_checker (
    // clock and reset
    input wire        clk,
    input wire        sys_rst,
    // bus
    input wire [3:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    // system
    input wire        wdt_clk_tick,
    input wire        cpu_halted,
    input wire        match_irq_q,
    input wire        chip_reset_req_q
);
    logic        wr_q;
    logic [31:0] cr_q;
    wire         rd_cr = avs_read && avs_address == 4'h4 && !avs_waitrequest;

    // shadow of the one control write; later ones must leave no trace
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_q <= 1'b0;
            cr_q <= `WWD_CR_RESET;
        end
        else if (avs_write && avs_address == 4'h4 && !avs_waitrequest && !wr_q)
        begin
            wr_q <= 1'b1;
            cr_q <= avs_writedata & `WWD_CR_MASK;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    answer_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("bus answer late");
    wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without request");
    ctrl_reset_a: assert property (rd_cr && !wr_q |-> avs_readdata == `WWD_CR_RESET)
        else $error("control reset value wrong");
    ctrl_once_a: assert property (rd_cr && wr_q |-> avs_readdata == cr_q)
        else $error("control changed after first write");
    irq_gate_a: assert property (match_irq_q |-> cr_q[1])
        else $error("interrupt while disabled");
    rst_needs_en_a: assert property ($rose(chip_reset_req_q) |-> cr_q[0])
        else $error("reset request while stopped");
    rst_pulse_a: assert property ($rose(chip_reset_req_q) |-> chip_reset_req_q[*3])
        else $error("reset request too short");
endmodule // wwd_checker

bind wwd_top wwd_checker wwd_checker_i (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .wdt_clk_tick(wdt_clk_tick), .cpu_halted(cpu_halted),
    .match_irq_q(match_irq_q), .chip_reset_req_q(chip_reset_req_q));

// *** verification/testbench.sv ***
/*
  bench of the window watchdog top.
  assumes wwd_top and its checker are compiled first.
*/
`include "wwd_defines.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        wdt_clk_tick = 1'b0;
    logic        cpu_halted = 1'b0;
    logic        match_irq_q;
    logic        chip_reset_req_q;
    logic        tick_on = 1'b0;
    logic [31:0] rd;
    int          err_total = 0;
    int          cmp_count = 0;

    wwd_top wwd_top_i (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .wdt_clk_tick(wdt_clk_tick),
        .cpu_halted(cpu_halted), .match_irq_q(match_irq_q),
        .chip_reset_req_q(chip_reset_req_q));

    always #20 clk = ~clk;

    // watchdog clock as a pulse every second cycle, stoppable by the bench
    always @(posedge clk)
        wdt_clk_tick <= tick_on && !wdt_clk_tick;

    task automatic stop_test();
        if (err_total == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // one avalon access; holds everything until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_address   <= a;
        avs_writedata <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic rst_dut();
        sys_rst <= 1'b1;
        tick_on <= 1'b0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    // reset values, unmapped read, key refused while stopped
    task automatic t_reset_map();
        rst_dut();
        bus(0, 4'h4, 0);
        `CHK(rd, `WWD_CR_RESET)
        bus(0, 4'hC, 0);
        `CHK(rd[5:0], `WWD_COUNT_TOP)
        bus(0, 4'h2, 0);
        `CHK(rd, 32'h0000_0000)
        tick_on <= 1'b1;
        bus(1, 4'h0, `WWD_RELOAD_KEY);
        repeat (20) @(posedge clk);
        bus(0, 4'hC, 0);
        `CHK(rd[5:0], `WWD_COUNT_TOP)
        `CHK(chip_reset_req_q, 1'b0)
    endtask

    // write-once, halt freeze, match flag, good and early reload
    task automatic t_window();
        logic [31:0] c;
        int          n;
        // divisor 2 keeps the count at top for four cycles after a reload,
        // longer than one read, so the polling below cannot step over it
        bus(1, 4'h4, 32'h003C_0103);
        bus(1, 4'h4, 32'h0000_0000);
        bus(0, 4'h4, 0);
        `CHK(rd, 32'h003C_0103)
        cpu_halted <= 1'b1;
        bus(0, 4'hC, 0);
        c = rd;
        repeat (40) @(posedge clk);
        bus(0, 4'hC, 0);
        `CHK(rd, c)
        cpu_halted <= 1'b0;
        n = 0;
        while (match_irq_q !== 1'b1 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        `CHK(match_irq_q, 1'b1)
        bus(0, 4'h8, 0);
        `CHK(rd[0], 1'b1)
        bus(1, 4'h8, 32'h0000_0001);
        bus(0, 4'h8, 0);
        `CHK(rd[0], 1'b0)
        bus(1, 4'h0, `WWD_RELOAD_KEY);
        n = 0;
        do
        begin
            bus(0, 4'hC, 0);
            n++;
        end
        while (rd[5:0] !== `WWD_COUNT_TOP && n < 20);
        // freeze the count at top so the next key lands above the window
        tick_on <= 1'b0;
        `CHK(rd[5:0], `WWD_COUNT_TOP)
        `CHK(chip_reset_req_q, 1'b0)
        bus(1, 4'h0, `WWD_RELOAD_KEY);
        n = 0;
        while (chip_reset_req_q !== 1'b1 && n < 6)
        begin
            @(posedge clk);
            n++;
        end
        `CHK(chip_reset_req_q, 1'b1)
    endtask

    // unattended time-out length for one prescale code
    task automatic t_timeout(input int code);
        int t;
        int n;
        int d;
        rst_dut();
        tick_on <= 1'b1;
        bus(1, 4'h4, 32'h003F_0001 | (code << 8));
        t = 0;
        n = 0;
        d = (code < 8) ? (1 << code) : 192;
        while (chip_reset_req_q !== 1'b1 && n < 30000)
        begin
            @(posedge clk);
            t += wdt_clk_tick;
            n++;
        end
        `CHK(t >= 63 * d - 1 && t <= 64 * d + 3, 1'b1)
    endtask

    initial
    begin
        t_reset_map();
        t_window();
        for (int k = 0; k < 9; k++)
            t_timeout(k);
        stop_test();
    end

    initial
    begin
        repeat (95000) @(posedge clk);
        err_total++;
        stop_test();
    end
endmodule // testbench
